// File: core/aic_pkg.sv
// Constants and carrier types for the analog input acquisition control block
package aic_pkg;

  // Register byte offsets inside the analog input window
  localparam logic [4:0] OFS_POLL = 5'h00;
  localparam logic [4:0] OFS_TRIG = 5'h04;
  localparam logic [4:0] OFS_DIV  = 5'h08;
  localparam logic [4:0] OFS_CNT  = 5'h0c;
  localparam logic [4:0] OFS_SCAN = 5'h10;
  localparam logic [4:0] OFS_BASE = 5'h14;
  localparam logic [4:0] OFS_RUN  = 5'h18;

  // Field positions
  localparam int BIT_FLUSH   = 15;
  localparam int SLOT_LSB    = 10;
  localparam int SLOT_MSB    = 14;
  localparam int ST_FULL_N   = 15;
  localparam int ST_HALF_N   = 14;
  localparam int ST_EMPTY_N  = 13;
  localparam int ST_BUSY     = 12;
  localparam int ST_JUMPER   = 11;
  localparam int RUN_START   = 15;
  localparam int RUN_STOP    = 14;

  // Reset values
  localparam logic [7:0]  SEL_RST  = 8'h10;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [11:0] BASE_RST = 12'h000;

  // Limits and timing
  localparam logic [15:0] CNT_MAX        = 16'd5000;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          BASE_UNIT_HZ   = 62_500;
  localparam int          BASE_TOP_HZ    = 8_000_000;
  localparam logic [8:0]  BASE_MOD       = 9'(CLK_HZ / BASE_UNIT_HZ);
  localparam logic [7:0]  BASE_TOP_UNITS = 8'(BASE_TOP_HZ / BASE_UNIT_HZ);
  localparam logic [3:0]  BASE_CODE_MAX  = 4'h7;
  localparam logic [1:0]  GRP_SE_HIGH    = 2'b10;
  localparam logic [1:0]  GRP_DIFFERENTIAL_INPUT       = 2'b11;

  typedef enum logic [2:0] {
    MODE_POLL     = 3'h0,
    MODE_PACER    = 3'h1,
    MODE_PACER_DC = 3'h2,
    MODE_POST_DC  = 3'h3,
    MODE_MID_DC   = 3'h4,
    MODE_PRE_DC   = 3'h5
  } aic_mode_t;

  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] group;
    logic [3:0] chan;
  } aic_sel_t;

  typedef struct packed {
    logic [3:0] code;
    logic [4:0] len;
    logic [2:0] mode;
  } aic_base_t;

endpackage : aic_pkg

// File: core/aic_fifo.sv
// Sample FIFO with clear, valid/ready on both sides and level flags
`timescale 1ns/10ps
module aic_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  input  wire logic             clear_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  full_o,
  output logic                  half_o,
  output logic                  empty_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i && !clear_i;
  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH)) || clear_i;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem[rp_reg];
  assign full_o      = (cnt_reg == (AW+1)'(DEPTH));
  assign half_o      = (cnt_reg >= (AW+1)'(DEPTH / 2));
  assign empty_o     = (cnt_reg == '0);

  always_comb begin
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (clear_i) begin
      // A sample landing with the clear survives it
      rp_next  = wp_reg;
      wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
      cnt_next = push ? (AW+1)'(1) : '0;
    end else begin
      if (push) wp_next = AW'(wp_reg + 1'b1);
      if (pop)  rp_next = AW'(rp_reg + 1'b1);
      cnt_next = (AW+1)'(cnt_reg + (push ? 1 : 0) - (pop ? 1 : 0));
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) mem[wp_reg] <= in_data_i;
  end

  a_fifo_bound: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");

endmodule : aic_fifo

// File: core/aic_acq_ctrl.sv
// Analog input acquisition control: registers, pacer, scan sequencer, converter handshake
//
// Functional notes
// - Poll config bit 15 write empties FIFO
// - Gain code bits 7:6 select input span
// - Group bits 5:4 select SE low/high/differential
// - Converted input is group base plus index
// - Write to 0x04 starts one polled conversion
// - Read of 0x04 pops oldest sample
// - Paced rate is base frequency over divisor
// - Divider fed by base frequency from 0x14
// - Scan sample count register, capped at 5000
// - Write 0x10 stores slot gain and input
// - Pacer config bit 15 also empties FIFO
// - Pacer config uses same field encoding
// - Status bit 11 shows input type jumper
// - Status bit 14 low when half full
// - Status bit 13 low when FIFO empty
// - Base code halves 8 MHz per step
// - Scan length field holds channels minus one
// - Three bit acquisition mode field
// - Bit 15 at 0x18 starts, 14 stops
`timescale 1ns/10ps
module aic_acq_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int SLOTS      = 32
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             adc_start_o,
  output logic [4:0]       adc_chan_o,
  output logic             adc_differential_input_o,
  output logic [1:0]       adc_gain_o,
  input  wire logic        adc_done_i,
  input  wire logic [15:0] adc_data_i,
  input  wire logic        input_type_jumper_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic        done_s1, done_s2, done_s3, jmp_s1, jmp_s2;
  logic [15:0] data_s1, data_s2;
  logic        done_rise;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      jmp_s1  <= 1'b0;
      jmp_s2  <= 1'b0;
      data_s1 <= 16'h0000;
      data_s2 <= 16'h0000;
    end else begin
      done_s1 <= adc_done_i;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      jmp_s1  <= input_type_jumper_i;
      jmp_s2  <= jmp_s1;
      data_s1 <= adc_data_i;
      data_s2 <= data_s1;
    end
  end

  // Data must settle before done rises; it then passes the same two stages
  assign done_rise = done_s2 && !done_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic wr_poll, wr_trig, wr_div, wr_cnt, wr_scan, wr_base, wr_run, rd_pop, flush;

  assign wr_poll = reg_wr_i && (reg_addr_i == aic_pkg::OFS_POLL);
  assign wr_trig = reg_wr_i && (reg_addr_i == aic_pkg::OFS_TRIG);
  assign wr_div  = reg_wr_i && (reg_addr_i == aic_pkg::OFS_DIV);
  assign wr_cnt  = reg_wr_i && (reg_addr_i == aic_pkg::OFS_CNT);
  assign wr_scan = reg_wr_i && (reg_addr_i == aic_pkg::OFS_SCAN);
  assign wr_base = reg_wr_i && (reg_addr_i == aic_pkg::OFS_BASE);
  assign wr_run  = reg_wr_i && (reg_addr_i == aic_pkg::OFS_RUN);
  assign rd_pop  = reg_rd_i && (reg_addr_i == aic_pkg::OFS_TRIG);
  assign flush   = (wr_poll || wr_scan) && reg_wdata_i[aic_pkg::BIT_FLUSH];

  aic_pkg::aic_sel_t  poll_sel_reg, poll_sel_next;
  aic_pkg::aic_base_t base_reg, base_next;
  logic [15:0]        div_reg, div_next, cnt_reg, cnt_next;
  aic_pkg::aic_sel_t  tab_mem [SLOTS];

  always_comb begin
    poll_sel_next = poll_sel_reg;
    base_next     = base_reg;
    div_next      = div_reg;
    cnt_next      = cnt_reg;
    if (wr_poll) poll_sel_next = reg_wdata_i[7:0];
    if (wr_base) base_next = reg_wdata_i[11:0];
    if (wr_div)  div_next = reg_wdata_i;
    if (wr_cnt) begin
      cnt_next = (reg_wdata_i > aic_pkg::CNT_MAX) ? aic_pkg::CNT_MAX : reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      poll_sel_reg <= aic_pkg::SEL_RST;
      base_reg     <= aic_pkg::BASE_RST;
      div_reg      <= aic_pkg::DIV_RST;
      cnt_reg      <= aic_pkg::CNT_RST;
    end else begin
      poll_sel_reg <= poll_sel_next;
      base_reg     <= base_next;
      div_reg      <= div_next;
      cnt_reg      <= cnt_next;
    end
  end

  // Scan table holds no reset; software must fill the slots it scans
  always_ff @(posedge clk_sys_i) begin
    if (wr_scan) tab_mem[reg_wdata_i[aic_pkg::SLOT_MSB:aic_pkg::SLOT_LSB]] <= reg_wdata_i[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Base frequency and pacer divisor
  logic [7:0]  acc_reg, acc_next, base_inc;
  logic [8:0]  acc_sum;
  logic [15:0] pdiv_reg, pdiv_next, div_eff;
  logic [3:0]  code_eff;
  logic        base_tick, pace_tick;

  always_comb begin
    code_eff  = (base_reg.code > aic_pkg::BASE_CODE_MAX) ? aic_pkg::BASE_CODE_MAX : base_reg.code;
    base_inc  = aic_pkg::BASE_TOP_UNITS >> code_eff;
    acc_sum   = {1'b0, acc_reg} + {1'b0, base_inc};
    base_tick = (acc_sum >= aic_pkg::BASE_MOD);
    acc_next  = base_tick ? 8'(acc_sum - aic_pkg::BASE_MOD) : acc_sum[7:0];
    // A zero divisor acts as one
    div_eff   = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
    pace_tick = 1'b0;
    pdiv_next = pdiv_reg;
    if (base_tick) begin
      if (16'(pdiv_reg + 1'b1) >= div_eff) begin
        pace_tick = 1'b1;
        pdiv_next = 16'h0000;
      end else begin
        pdiv_next = 16'(pdiv_reg + 1'b1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control, scan slot and conversion sequencer
  typedef enum logic [1:0] {CV_IDLE, CV_START, CV_WAIT, CV_PUSH} aic_cv_state_t;

  aic_cv_state_t     cv_reg, cv_next;
  aic_pkg::aic_sel_t sel_reg, sel_next;
  logic [15:0]       smp_reg, smp_next, done_cnt_reg, done_cnt_next;
  logic [4:0]        slot_reg, slot_next;
  logic              run_reg, run_next, pend_reg, pend_next, paced_reg, paced_next, start_next;
  logic              fifo_in_ready, fifo_full, fifo_half, fifo_empty, fifo_out_valid, take_pace;
  logic [15:0]       fifo_out_data;
  logic              count_mode;

  assign count_mode = (base_reg.mode >= aic_pkg::MODE_PACER_DC) && (base_reg.mode <= aic_pkg::MODE_PRE_DC);

  always_comb begin
    cv_next       = cv_reg;
    sel_next      = sel_reg;
    smp_next      = smp_reg;
    slot_next     = slot_reg;
    run_next      = run_reg;
    paced_next    = paced_reg;
    done_cnt_next = done_cnt_reg;
    start_next    = 1'b0;
    take_pace     = 1'b0;
    // A tick is held until taken; a new tick in the take cycle is kept
    pend_next     = pend_reg;
    case (cv_reg)
      CV_IDLE: begin
        if (wr_trig) begin
          sel_next   = poll_sel_reg;
          paced_next = 1'b0;
          start_next = 1'b1;
          cv_next    = CV_START;
        end else if (pend_reg && run_reg) begin
          take_pace  = 1'b1;
          sel_next   = tab_mem[slot_reg];
          paced_next = 1'b1;
          start_next = 1'b1;
          slot_next  = (slot_reg >= base_reg.len) ? 5'h00 : 5'(slot_reg + 1'b1);
          cv_next    = CV_START;
        end
      end
      CV_START: cv_next = CV_WAIT;
      CV_WAIT: begin
        if (done_rise) begin
          smp_next = data_s2;
          cv_next  = CV_PUSH;
        end
      end
      CV_PUSH: begin
        // A full FIFO stalls the sequencer; pacer ticks meanwhile collapse into one
        if (fifo_in_ready) begin
          cv_next = CV_IDLE;
          if (paced_reg && count_mode) begin
            done_cnt_next = 16'(done_cnt_reg + 1'b1);
            if (16'(done_cnt_reg + 1'b1) >= cnt_reg) run_next = 1'b0;
          end
        end
      end
      default: cv_next = CV_IDLE;
    endcase
    if (take_pace) pend_next = 1'b0;
    if (pace_tick && run_reg) pend_next = 1'b1;
    if (wr_run && reg_wdata_i[aic_pkg::RUN_START] && base_reg.mode != aic_pkg::MODE_POLL) begin
      run_next      = 1'b1;
      slot_next     = 5'h00;
      done_cnt_next = 16'h0000;
    end
    // Stop wins over start in the same write
    if (wr_run && reg_wdata_i[aic_pkg::RUN_STOP]) begin
      run_next  = 1'b0;
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cv_reg       <= CV_IDLE;
      sel_reg      <= aic_pkg::SEL_RST;
      smp_reg      <= 16'h0000;
      slot_reg     <= 5'h00;
      run_reg      <= 1'b0;
      pend_reg     <= 1'b0;
      paced_reg    <= 1'b0;
      done_cnt_reg <= 16'h0000;
      acc_reg      <= 8'h00;
      pdiv_reg     <= 16'h0000;
      adc_start_o  <= 1'b0;
      adc_chan_o   <= 5'h00;
      adc_differential_input_o   <= 1'b0;
      adc_gain_o   <= 2'b00;
    end else begin
      cv_reg       <= cv_next;
      sel_reg      <= sel_next;
      smp_reg      <= smp_next;
      slot_reg     <= slot_next;
      run_reg      <= run_next;
      pend_reg     <= pend_next;
      paced_reg    <= paced_next;
      done_cnt_reg <= done_cnt_next;
      acc_reg      <= acc_next;
      pdiv_reg     <= run_reg ? pdiv_next : 16'h0000;
      adc_start_o  <= start_next;
      // Undefined group code 00 is treated as the low single-ended set
      adc_chan_o   <= {sel_next.group == aic_pkg::GRP_SE_HIGH, sel_next.chan};
      adc_differential_input_o   <= (sel_next.group == aic_pkg::GRP_DIFFERENTIAL_INPUT);
      adc_gain_o   <= sel_next.gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample FIFO
  aic_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .clear_i     (flush),
    .in_valid_i  (cv_reg == CV_PUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (smp_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rd_pop),
    .out_data_o  (fifo_out_data),
    .full_o      (fifo_full),
    .half_o      (fifo_half),
    .empty_o     (fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [15:0] rdata_next, status;

  always_comb begin
    status = 16'h0000;
    status[aic_pkg::ST_FULL_N]  = !fifo_full;
    status[aic_pkg::ST_HALF_N]  = !fifo_half;
    status[aic_pkg::ST_EMPTY_N] = !fifo_empty;
    status[aic_pkg::ST_BUSY]    = (cv_reg != CV_IDLE);
    status[aic_pkg::ST_JUMPER]  = jmp_s2;
    case (reg_addr_i)
      aic_pkg::OFS_POLL: rdata_next = {8'h00, poll_sel_reg};
      aic_pkg::OFS_TRIG: rdata_next = fifo_out_valid ? fifo_out_data : 16'h0000;
      aic_pkg::OFS_DIV:  rdata_next = div_reg;
      aic_pkg::OFS_CNT:  rdata_next = cnt_reg;
      aic_pkg::OFS_SCAN: rdata_next = status;
      aic_pkg::OFS_BASE: rdata_next = {4'h0, base_reg};
      default:           rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= reg_rd_i ? rdata_next : 16'h0000;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_soft_take;
    cv_reg == CV_IDLE && wr_trig;
  endsequence

  sequence s_start_pulse;
    adc_start_o && cv_reg == CV_START ##1 !adc_start_o && cv_reg == CV_WAIT;
  endsequence

  a_poll_flush: assert property (wr_poll && reg_wdata_i[15] && cv_reg != CV_PUSH |=> fifo_empty)
    else $error("Poll flush left samples");
  a_pacer_flush: assert property (wr_scan && reg_wdata_i[15] && cv_reg != CV_PUSH |=> fifo_empty)
    else $error("Pacer flush left samples");
  a_soft_start: assert property (s_soft_take |=> s_start_pulse ##0 adc_gain_o == $past(poll_sel_reg.gain, 2))
    else $error("Soft trigger did not start conversion");
  a_chan_map: assert property (adc_start_o |-> adc_chan_o[3:0] == sel_reg.chan
    && adc_chan_o[4] == (sel_reg.group == 2'b10) && adc_differential_input_o == (sel_reg.group == 2'b11))
    else $error("Channel mapping wrong");
  a_pop_data: assert property (rd_pop && fifo_out_valid |=> reg_rvalid_o && reg_rdata_o == $past(fifo_out_data))
    else $error("Pop returned wrong sample");
  a_status_flags: assert property (reg_rd_i && reg_addr_i == 5'h10 |=>
    reg_rdata_o[15:12] == {!$past(fifo_full), !$past(fifo_half), !$past(fifo_empty), $past(cv_reg) != CV_IDLE})
    else $error("Status flags wrong");
  a_cnt_cap: assert property (wr_cnt && reg_wdata_i > 16'd5000 |=> cnt_reg == 16'd5000)
    else $error("Sample count not capped");
  a_scan_wrap: assert property (take_pace && slot_reg >= base_reg.len && !wr_run |=> slot_reg == 5'h00)
    else $error("Scan slot did not wrap");
  a_run_stop: assert property (wr_run && reg_wdata_i[14] |=> !run_reg ##1 !take_pace)
    else $error("Stop did not halt pacer");
  a_push_done: assert property (cv_reg == CV_WAIT && done_rise |=> cv_reg == CV_PUSH ##0 smp_reg == $past(data_s2))
    else $error("Sample not captured on done");

endmodule : aic_acq_ctrl

// File: verification/aic_adc_model.sv
// Behavioural converter that answers the block's start pulses
`timescale 1ns/10ps
module aic_adc_model (
  input  wire logic        clk_sys_i,
  input  wire logic        slow_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  chan_i,
  input  wire logic        differential_input_i,
  input  wire logic [1:0]  gain_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Result encodes the selection so the bench can tell which input was converted
  initial begin
    done_o = 1'b0;
    data_o = 16'h0000;
    forever begin
      @(posedge clk_sys_i);
      if (start_i === 1'b1) begin
        repeat (slow_i ? 20 : 2) @(posedge clk_sys_i);
        data_o <= {4'ha, gain_i, differential_input_i, chan_i, 4'h5};
        // Data settles three edges ahead of done, as the synchroniser needs
        repeat (3) @(posedge clk_sys_i);
        done_o <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        done_o <= 1'b0;
        // Stale data is inverted so a late sample cannot match by chance
        data_o <= ~data_o;
      end
    end
  end
endmodule : aic_adc_model

// File: verification/aic_acq_ctrl_tb_top.sv
// Self-checking testbench for the analog input acquisition control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module aic_acq_ctrl_tb_top;
  logic        clk_sys_i, nrst_i, reg_wr, reg_rd, jumper, slow, adc_start, adc_differential_input, adc_done, rvalid;
  logic [4:0]  reg_addr, adc_chan;
  logic [1:0]  adc_gain;
  logic [15:0] reg_wdata, rdata, adc_data, st, d, e16, q[$];
  logic [7:0]  sel, slot_sel[3];
  logic [4:0]  ra[6] = '{5'h00, 5'h08, 5'h0c, 5'h14, 5'h18, 5'h1c};
  logic [15:0] rv[6] = '{16'h0010, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int          seed = 32'h01587e2f;
  int          err_count, compares, n, t0, cyc;

  aic_acq_ctrl #(.FIFO_DEPTH(8), .SLOTS(32)) aic_acq_ctrl_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .adc_start_o(adc_start), .adc_chan_o(adc_chan), .adc_differential_input_o(adc_differential_input),
    .adc_gain_o(adc_gain), .adc_done_i(adc_done), .adc_data_i(adc_data), .input_type_jumper_i(jumper));
  aic_adc_model aic_adc_model_i (.clk_sys_i(clk_sys_i), .slow_i(slow), .start_i(adc_start), .chan_i(adc_chan),
    .differential_input_i(adc_differential_input), .gain_i(adc_gain), .done_o(adc_done), .data_o(adc_data));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial cyc = 0;
  always @(posedge clk_sys_i) cyc <= cyc + 1;

  function automatic logic [4:0] exp_chan(input logic [7:0] s);
    return {s[5:4] == 2'b10, s[3:0]};
  endfunction : exp_chan
  function automatic logic [15:0] exp_data(input logic [7:0] s);
    return {4'ha, s[7:6], s[5:4] == 2'b11, exp_chan(s), 4'h5};
  endfunction : exp_data

  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    // One idle edge between strobes keeps back-to-back calls apart
    tick();
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    tick();
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    v = rdata;
  endtask : rd
  task automatic chk_st(input int k);
    rd(aic_pkg::OFS_SCAN, st);
    `CHK("status", {k != 8, k < 4, k != 0, 1'b0, jumper, 11'h000}, st)
  endtask : chk_st
  // Busy is polled, not waited out, because converter latency varies
  task automatic conv(input logic [7:0] s);
    wr(aic_pkg::OFS_POLL, {8'h00, s});
    wr(aic_pkg::OFS_TRIG, 16'($random(seed)));
    `CHK("start", 1'b1, adc_start)
    `CHK("chan", exp_chan(s), adc_chan)
    `CHK("differential_input", s[5:4] == 2'b11, adc_differential_input)
    `CHK("gain", s[7:6], adc_gain)
    rd(aic_pkg::OFS_SCAN, st);
    `CHK("busy", 1'b1, st[12])
    for (int i = 0; i < 80 && st[12] !== 1'b0; i++) rd(aic_pkg::OFS_SCAN, st);
    q.push_back(exp_data(s));
  endtask : conv
  task automatic pop;
    rd(aic_pkg::OFS_TRIG, d);
    e16 = q.pop_front();
    `CHK("sample", e16, d)
  endtask : pop
  task automatic count_starts(input int c, output int k);
    k = 0;
    repeat (c) begin
      tick();
      if (adc_start === 1'b1) k++;
    end
  endtask : count_starts
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    err_count++;
    stop_test();
  end

  initial begin
    {nrst_i, reg_wr, reg_rd, reg_addr, reg_wdata, slow} = '0;
    jumper = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d);
      `CHK("reset value", rv[i], d)
    end
    chk_st(0);
    wr(aic_pkg::OFS_CNT, 16'h1770);
    rd(aic_pkg::OFS_CNT, d);
    `CHK("count cap", 16'h1388, d)
    wr(aic_pkg::OFS_CNT, 16'h1387);
    rd(aic_pkg::OFS_CNT, d);
    `CHK("count", 16'h1387, d)
    // Every gain and group code, random index, prompt and slow converter
    for (int i = 0; i < 16; i++) begin
      sel = {i[1:0], i[3:2], 4'($random(seed))};
      slow = i[0];
      jumper = 1'($random(seed));
      conv(sel);
      rd(aic_pkg::OFS_POLL, d);
      `CHK("poll cfg", {8'h00, sel}, d)
      chk_st(1);
      pop();
      chk_st(0);
    end
    for (int i = 0; i < 8; i++) begin
      conv(8'($random(seed)));
      chk_st(i + 1);
    end
    pop();
    pop();
    chk_st(6);
    wr(aic_pkg::OFS_SCAN, 16'h8000);
    chk_st(0);
    q.delete();
    conv(8'h35);
    conv(8'h2a);
    wr(aic_pkg::OFS_POLL, 16'h8010);
    chk_st(0);
    q.delete();
    rd(aic_pkg::OFS_TRIG, d);
    `CHK("empty pop", 16'h0000, d)
    // Three-slot scan at 62.5 kHz over two
    wr(aic_pkg::OFS_BASE, 16'h0711);
    wr(aic_pkg::OFS_DIV, 16'h0002);
    for (int k = 0; k < 3; k++) begin
      slot_sel[k] = 8'($random(seed));
      wr(aic_pkg::OFS_SCAN, 16'(k << 10) | {8'h00, slot_sel[k]});
    end
    rd(aic_pkg::OFS_BASE, d);
    `CHK("base cfg", 16'h0711, d)
    wr(aic_pkg::OFS_RUN, 16'h8000);
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 400 && adc_start !== 1'b1; j++) tick();
      `CHK("scan chan", exp_chan(slot_sel[k % 3]), adc_chan)
      `CHK("scan gain", slot_sel[k % 3][7:6], adc_gain)
      if (k > 0) `CHK("pacer period", 320, cyc - t0)
      t0 = cyc;
      q.push_back(exp_data(slot_sel[k % 3]));
      tick();
    end
    wr(aic_pkg::OFS_RUN, 16'h4000);
    count_starts(700, n);
    `CHK("starts after stop", 0, n)
    chk_st(7);
    repeat (7) pop();
    // Polling mode ignores start; counted modes stop after two samples
    wr(aic_pkg::OFS_DIV, 16'd80);
    for (int m = 0; m < 6; m++) if (m != 1) begin
      wr(aic_pkg::OFS_SCAN, 16'h8013);
      wr(aic_pkg::OFS_CNT, 16'h0002);
      wr(aic_pkg::OFS_BASE, 16'(m));
      wr(aic_pkg::OFS_RUN, 16'h8000);
      count_starts(600, n);
      `CHK("counted starts", (m == 0) ? 0 : 2, n)
      wr(aic_pkg::OFS_RUN, 16'h4000);
    end
    // Base codes 0 to 6, divisor scaled so each pacer period is 320 cycles
    for (int c = 0; c < 7; c++) begin
      wr(aic_pkg::OFS_SCAN, 16'h8013);
      wr(aic_pkg::OFS_BASE, 16'(c << 8) | 16'h0001);
      wr(aic_pkg::OFS_DIV, 16'(256 >> c));
      wr(aic_pkg::OFS_RUN, 16'h8000);
      for (int k = 0; k < 2; k++) begin
        for (int j = 0; j < 700 && adc_start !== 1'b1; j++) tick();
        if (k > 0) `CHK("base period", 320, cyc - t0)
        t0 = cyc;
        tick();
      end
      wr(aic_pkg::OFS_RUN, 16'h4000);
    end
    stop_test();
  end
endmodule : aic_acq_ctrl_tb_top
